// ==== hw/tcc_defs.svh ====
// offsets, fields, reset values and timing of the conversion control
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

`define TCC_CLK_MHZ        125

`define TCC_REG_CONV_CTL   8'h01
`define TCC_REG_CTL2       8'h02
`define TCC_REG_SEQ        8'h03
`define TCC_REG_RES_FIRST  8'h08
`define TCC_REG_RES_LAST   8'h0d
`define TCC_REG_ID         8'h0e

`define TCC_CC_RESET       16'h0000
`define TCC_C2_RESET       16'h4040
`define TCC_SEQ_RESET      16'h0000

`define TCC_F_TMR          7:0
`define TCC_F_ACQ          9:8
`define TCC_F_MODE         11:10
`define TCC_F_CHAN         14:12
`define TCC_B_ALERT_OFF    15
`define TCC_F_PWR          15:14
`define TCC_B_SER          9
`define TCC_F_FCD          3:0
`define TCC_F_SEQ          7:1
`define TCC_B_VBAT         2
`define TCC_B_AUX          3

`define TCC_ACQ_BASE_NS    2000
`define TCC_ACQ_BASE_CYC   ((`TCC_ACQ_BASE_NS * `TCC_CLK_MHZ + 999) / 1000)
`define TCC_TMR_BASE_US    550
`define TCC_TMR_BASE_CYC   (`TCC_TMR_BASE_US * `TCC_CLK_MHZ)
`define TCC_TMR_STEP_US    35
`define TCC_TMR_STEP_CYC   (`TCC_TMR_STEP_US * `TCC_CLK_MHZ)
`define TCC_SETTLE_US      128
`define TCC_SETTLE_CYC     (`TCC_SETTLE_US * `TCC_CLK_MHZ)

`endif

// ==== hw/tcc_pkg.sv ====
// types shared by the conversion control modules
package tcc_pkg;

  typedef enum logic [1:0] {
    MODE_IDLE   = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_SLAVE  = 2'b10,
    MODE_MASTER = 2'b11
  } tcc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETTLE = 3'b001,
    ST_ACQ    = 3'b010,
    ST_CONV   = 3'b011,
    ST_NEXT   = 3'b100
  } tcc_state_t;

  typedef enum logic [1:0] {
    REF_SUPPLY = 2'b00,
    REF_Y      = 2'b01,
    REF_X      = 2'b10,
    REF_PRESS  = 2'b11
  } tcc_ref_t;

  typedef struct packed {
    logic     xp;
    logic     xm;
    logic     yp;
    logic     ym;
    tcc_ref_t refsel;
  } tcc_sw_t;

  typedef struct packed {
    tcc_state_t  st;
    logic [15:0] cc;
    logic [15:0] c2;
    logic [15:0] seq;
    logic [2:0]  chan;
    logic [23:0] cnt;
    logic [23:0] tmr;
    logic        tmr_run;
    logic        start_pend;
    logic        touch_prev;
    tcc_sw_t     sw;
    logic        sample_window_select;
    logic        conv_start;
    logic        alert_n;
    logic        res_we;
    logic [2:0]  res_idx;
    logic [15:0] res_dat;
    logic        rd_p;
    logic        rd_mem_p;
    logic [15:0] rd_ctl_p;
    logic        rd_vld;
    logic [15:0] rd_data;
  } tcc_st_t;

endpackage

// ==== hw/tcc_res_if.sv ====
// result store port between the control and its memory
`timescale 1ns/1ps
interface tcc_res_if #(parameter int AW = 3, parameter int DW = 16);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// ==== hw/tcc_res_mem.sv ====
// result register memory with registered read data
`timescale 1ns/1ps
module tcc_res_mem #(
  parameter int DEPTH = 6
) (
  // clock and reset
  input  logic   ref_clk,
  input  logic   sys_rst,
  // access
  tcc_res_if.mem res
);
  import tcc_pkg::*;

  logic [15:0] mem_q [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 16'h0000;
      end
      res.rdata <= 16'h0000;
    end else begin
      if (res.we && (int'(res.waddr) < DEPTH)) begin
        mem_q[res.waddr] <= res.wdata;
      end
      res.rdata <= (int'(res.raddr) < DEPTH) ? mem_q[res.raddr] : 16'h0000;
    end
  end
endmodule // tcc_res_mem

// ==== hw/tcc_conv_ctl.sv ====
// conversion control of the touch screen converter
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_conv_ctl #(
  parameter int unsigned TMR_BASE_CYC    = `TCC_TMR_BASE_CYC,
  parameter int unsigned TMR_STEP_CYC    = `TCC_TMR_STEP_CYC,
  parameter int unsigned SETTLE_UNIT_CYC = `TCC_SETTLE_CYC,
  // identity value is arbitrary
  parameter logic [15:0] DEVICE_ID       = 16'h5a01
) (
  // clock and reset
  input  logic             ref_clk,
  input  logic             sys_rst,
  // register port
  input  logic             reg_wr,
  input  logic             reg_rd,
  input  logic [7:0]       reg_addr,
  input  logic [15:0]      reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_rvalid,
  // screen and converter
  input  logic             touch_sense,
  input  logic             limit_hit,
  input  logic             conv_done,
  input  logic [11:0]      conv_data,
  output logic [2:0]       adc_chan,
  output tcc_pkg::tcc_sw_t plate_sw,
  output logic             acq_active,
  output logic             conv_start,
  output logic             shutdown,
  // shared alert pin
  output logic             touch_alert_n
);
  import tcc_pkg::*;

  tcc_st_t     s;
  tcc_st_t     n;
  tcc_mode_t   mode;
  logic        master;
  logic        fire;
  logic        pen;
  logic        go;
  logic        finish;
  logic [2:0]  nc;
  logic [7:0]  mask;
  tcc_res_if   res ();

  tcc_res_mem #(
    .DEPTH (6)
  ) u_mem (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .res     (res)
  );

  // sequencer mask; with both aux and battery set, battery wins
  function automatic logic [7:0] seq_mask(input logic [15:0] r);
    logic [7:0] m;
    m = {r[`TCC_F_SEQ], 1'b0};
    if (m[`TCC_B_VBAT]) begin
      m[`TCC_B_AUX] = 1'b0;
    end
    return m;
  endfunction

  // highest enabled code below cur; cur 0 means start at top
  function automatic logic [2:0] next_chan(input logic [7:0] m,
                                           input logic [2:0] cur);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (m[i] && (cur == 3'h0 || 3'(i) < cur)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // result slot of an input code
  function automatic logic [2:0] res_slot(input logic [2:0] code);
    case (code)
      3'h7:    return 3'h0;
      3'h6:    return 3'h1;
      3'h5:    return 3'h2;
      3'h4:    return 3'h3;
      3'h3:    return 3'h4;
      3'h2:    return 3'h4;
      default: return 3'h5;
    endcase
  endfunction

  // plate switches and reference for a code
  function automatic tcc_sw_t sw_cfg(input logic [2:0] code,
                                     input logic ser);
    tcc_sw_t w;
    w = '{xp: 1'b0, xm: 1'b0, yp: 1'b0, ym: 1'b0, refsel: REF_SUPPLY};
    case (code)
      3'h7: begin
        w.yp = 1'b1;
        w.ym = 1'b1;
        w.refsel = ser ? REF_SUPPLY : REF_Y;
      end
      3'h6: begin
        w.xp = 1'b1;
        w.xm = 1'b1;
        w.refsel = ser ? REF_SUPPLY : REF_X;
      end
      3'h5, 3'h4: begin
        if (!ser) begin
          w.xm = 1'b1;
          w.yp = 1'b1;
          w.refsel = REF_PRESS;
        end
      end
      default: w.refsel = REF_SUPPLY;
    endcase
    return w;
  endfunction

  function automatic logic [23:0] acq_cyc(input logic [1:0] sel);
    return 24'(`TCC_ACQ_BASE_CYC) << sel;
  endfunction

  function automatic logic [23:0] settle_cyc(input logic [3:0] fcd);
    logic [5:0] k;
    case (fcd)
      4'ha:    k = 6'd12;
      4'hb:    k = 6'd14;
      4'hc:    k = 6'd16;
      4'hd:    k = 6'd20;
      4'he:    k = 6'd28;
      4'hf:    k = 6'd32;
      default: k = 6'({2'b00, fcd} + 6'd1);
    endcase
    return 24'(SETTLE_UNIT_CYC * k);
  endfunction

  function automatic logic [23:0] tmr_cyc(input logic [7:0] code);
    return 24'(TMR_BASE_CYC + TMR_STEP_CYC * (code - 8'h01));
  endfunction

  assign mode   = tcc_mode_t'(s.cc[`TCC_F_MODE]);
  assign master = (mode == MODE_MASTER);
  assign mask   = seq_mask(s.seq);
  assign pen    = touch_sense && !s.touch_prev;

  always_comb begin
    n = s;
    n.conv_start = 1'b0;
    n.res_we = 1'b0;
    n.rd_vld = 1'b0;
    n.touch_prev = touch_sense;
    finish = 1'b0;
    go = 1'b0;
    fire = 1'b0;
    nc = 3'h0;
    // pen-down or limit report on the shared pin
    n.alert_n = s.cc[`TCC_B_ALERT_OFF] ? !limit_hit : !touch_sense;
    // register reads, two cycles to data
    n.rd_p = reg_rd;
    n.rd_mem_p = (reg_addr >= `TCC_REG_RES_FIRST) &&
                 (reg_addr <= `TCC_REG_RES_LAST);
    case (reg_addr)
      `TCC_REG_CONV_CTL: n.rd_ctl_p = s.cc;
      `TCC_REG_CTL2:     n.rd_ctl_p = s.c2;
      `TCC_REG_SEQ:      n.rd_ctl_p = s.seq;
      `TCC_REG_ID:       n.rd_ctl_p = DEVICE_ID;
      default:           n.rd_ctl_p = 16'h0000;
    endcase
    if (s.rd_p) begin
      n.rd_vld = 1'b1;
      n.rd_data = s.rd_mem_p ? res.rdata : s.rd_ctl_p;
    end
    // interval timer
    if (s.tmr_run) begin
      if (s.tmr == 24'h000000) begin
        fire = 1'b1;
        n.tmr_run = 1'b0;
      end else begin
        n.tmr = s.tmr - 24'h000001;
      end
    end
    if (master && !touch_sense) begin
      n.tmr_run = 1'b0;
      fire = 1'b0;
    end
    case (mode)
      MODE_SINGLE, MODE_SLAVE: go = s.start_pend || fire;
      MODE_MASTER: go = s.start_pend || pen || fire;
      default: go = 1'b0;
    endcase
    case (s.st)
      ST_IDLE: begin
        if (go) begin
          n.start_pend = 1'b0;
          if (mode == MODE_SINGLE) begin
            nc = s.cc[`TCC_F_CHAN];
          end else begin
            nc = next_chan(mask, 3'h0);
          end
          if (nc == 3'h0) begin
            finish = 1'b1;
          end else begin
            n.chan = nc;
            n.st = ST_SETTLE;
            n.cnt = settle_cyc(s.c2[`TCC_F_FCD]) - 24'h000001;
          end
        end
      end
      ST_SETTLE: begin
        if (s.cnt == 24'h000000) begin
          n.st = ST_ACQ;
          n.sample_window_select = 1'b1;
          n.cnt = acq_cyc(s.cc[`TCC_F_ACQ]) - 24'h000001;
        end else begin
          n.cnt = s.cnt - 24'h000001;
        end
      end
      ST_ACQ: begin
        if (s.cnt == 24'h000000) begin
          n.st = ST_CONV;
          n.sample_window_select = 1'b0;
          n.conv_start = 1'b1;
        end else begin
          n.cnt = s.cnt - 24'h000001;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          n.res_we = 1'b1;
          n.res_idx = res_slot(s.chan);
          n.res_dat = {4'h0, conv_data};
          n.st = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (mode != MODE_SINGLE) begin
          nc = next_chan(mask, s.chan);
        end
        if (nc == 3'h0) begin
          finish = 1'b1;
        end else begin
          n.chan = nc;
          if (nc >= 3'h4) begin
            n.st = ST_SETTLE;
            n.cnt = settle_cyc(s.c2[`TCC_F_FCD]) - 24'h000001;
          end else begin
            n.st = ST_ACQ;
            n.sample_window_select = 1'b1;
            n.cnt = acq_cyc(s.cc[`TCC_F_ACQ]) - 24'h000001;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // end of a pass: clear mode, rearm timer, or wait for touch
    if (finish) begin
      n.st = ST_IDLE;
      if (s.cc[`TCC_F_TMR] == 8'h00) begin
        if (!master) begin
          n.cc[`TCC_F_MODE] = MODE_IDLE;
        end
      end else if (!master || touch_sense) begin
        n.tmr_run = 1'b1;
        n.tmr = tmr_cyc(s.cc[`TCC_F_TMR]) - 24'h000001;
      end
    end
    // a write to the conversion control register aborts any pass in progress
    if (reg_wr) begin
      case (reg_addr)
        `TCC_REG_CONV_CTL: begin
          n.cc = reg_wdata;
          n.st = ST_IDLE;
          n.tmr_run = 1'b0;
          n.sample_window_select = 1'b0;
          n.conv_start = 1'b0;
          n.start_pend = 1'b0;
          case (tcc_mode_t'(reg_wdata[`TCC_F_MODE]))
            MODE_SINGLE, MODE_SLAVE: n.start_pend = 1'b1;
            MODE_MASTER: n.start_pend = touch_sense;
            default: n.start_pend = 1'b0;
          endcase
        end
        `TCC_REG_CTL2: n.c2 = reg_wdata;
        `TCC_REG_SEQ:  n.seq = reg_wdata;
        default: n.st = n.st;
      endcase
    end
    if (n.c2[`TCC_F_PWR] == 2'b00) begin
      n.st = ST_IDLE;
      n.tmr_run = 1'b0;
      n.start_pend = 1'b0;
      n.sample_window_select = 1'b0;
      n.conv_start = 1'b0;
    end
    n.sw = (n.st == ST_IDLE) ?
           '{xp: 1'b0, xm: 1'b0, yp: 1'b0, ym: 1'b0, refsel: REF_SUPPLY} :
           sw_cfg(n.chan, n.c2[`TCC_B_SER]);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.cc <= `TCC_CC_RESET;
      s.c2 <= `TCC_C2_RESET;
      s.seq <= `TCC_SEQ_RESET;
      s.alert_n <= 1'b1;
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end

  assign res.we      = s.res_we;
  assign res.waddr   = s.res_idx;
  assign res.wdata   = s.res_dat;
  assign res.raddr   = 3'(reg_addr - `TCC_REG_RES_FIRST);
  assign reg_rdata   = s.rd_data;
  assign reg_rvalid  = s.rd_vld;
  assign adc_chan    = s.chan;
  assign plate_sw    = s.sw;
  assign acq_active  = s.sample_window_select;
  assign conv_start  = s.conv_start;
  assign shutdown    = (s.c2[`TCC_F_PWR] == 2'b00);
  assign touch_alert_n = s.alert_n;

  // checks
  logic [23:0] acq_seen_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acq_seen_q <= 24'h000000;
    end else begin
      acq_seen_q <= s.sample_window_select ? acq_seen_q + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence seq_end_s;
    s.st == ST_NEXT && mode == MODE_SLAVE &&
      next_chan(mask, s.chan) == 3'h0 &&
      !reg_wr && s.c2[`TCC_F_PWR] != 2'b00;
  endsequence

  reset_zero_a: assert property (disable iff (1'b0)
    sys_rst |=> s.cc == 16'h0000 && s.st == ST_IDLE)
    else $error("control register not zero after reset");
  idle_halt_a: assert property (
    reg_wr && reg_addr == `TCC_REG_CONV_CTL &&
      reg_wdata[`TCC_F_MODE] == 2'b00
    |=> s.st == ST_IDLE && !s.tmr_run && !conv_start [*2])
    else $error("idle write did not halt conversions");
  single_clear_a: assert property (
    s.st == ST_NEXT && mode == MODE_SINGLE &&
      s.cc[`TCC_F_TMR] == 8'h00 && !reg_wr && s.c2[`TCC_F_PWR] != 2'b00
    |=> s.cc[`TCC_F_MODE] == 2'b00 && s.st == ST_IDLE)
    else $error("single mode did not clear mode field");
  acq_len_a: assert property (
    $fell(s.sample_window_select) && s.st == ST_CONV
    |-> acq_seen_q == acq_cyc(s.cc[`TCC_F_ACQ]))
    else $error("acquisition length wrong");
  shutdown_a: assert property (
    s.c2[`TCC_F_PWR] == 2'b00 |-> s.st == ST_IDLE && !s.sample_window_select ##1 !conv_start)
    else $error("conversion during shutdown");
  alert_pin_a: assert property (
    1'b1 |=> touch_alert_n ==
      ($past(s.cc[`TCC_B_ALERT_OFF]) ? !$past(limit_hit)
                                     : !$past(touch_sense)))
    else $error("alert pin source wrong");
  master_release_a: assert property (
    master && !touch_sense |=> !s.tmr_run)
    else $error("timer ran after touch release");
  slave_timer_a: assert property (
    seq_end_s ##0 (s.cc[`TCC_F_TMR] != 8'h00)
    |=> s.tmr_run && s.tmr == tmr_cyc($past(s.cc[`TCC_F_TMR])) - 24'h000001)
    else $error("slave timer not started at sequence end");
  diff_pos_a: assert property (
    s.st != ST_IDLE && s.chan == 3'h7 && !s.c2[`TCC_B_SER]
    |-> s.sw.yp && s.sw.ym && !s.sw.xp && !s.sw.xm && s.sw.refsel == REF_Y)
    else $error("differential Y position switches wrong");
  store_res_a: assert property (
    s.st == ST_CONV && conv_done && !reg_wr && s.c2[`TCC_F_PWR] != 2'b00
    |=> res.we && res.waddr == res_slot($past(s.chan)))
    else $error("result not stored after conversion");
endmodule // tcc_conv_ctl

// ==== bench/tcc_adc_model.sv ====
// converter stand-in answering conversion starts
`timescale 1ns/1ps
module tcc_adc_model (
  // clock
  input  logic        ref_clk,
  // converter handshake
  input  logic        conv_start,
  input  logic [2:0]  adc_chan,
  input  int          dly,
  output logic        conv_done = 1'b0,
  output logic [11:0] conv_data = 12'h000
);
  int         cnt = 0;
  logic [2:0] ch  = 3'h0;

  // data toggles outside the valid cycle
  always @(negedge ref_clk) begin
    conv_done <= (cnt == 1);
    conv_data <= (cnt == 1) ? {ch, 9'h0a5} : ~conv_data;
    if (cnt > 0) cnt <= cnt - 1;
    if (conv_start === 1'b1) begin
      cnt <= dly;
      ch  <= adc_chan;
    end
  end
endmodule // tcc_adc_model

// ==== bench/touch_adc_conversion_control_tb_top.sv ====
// self-checking bench of the conversion control
`timescale 1ns/1ps
`include "tcc_defs.svh"
`define CHK(nm, ex, got) begin checks_done++; \
  if ((got) !== (ex)) begin n_errors++; \
  $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module touch_adc_conversion_control_tb_top;
  import tcc_pkg::*;
  logic        ref_clk     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [15:0] reg_wdata   = 16'h0000;
  logic        touch_sense = 1'b0;
  logic        limit_hit   = 1'b0;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        conv_done;
  logic [11:0] conv_data;
  logic [2:0]  adc_chan;
  tcc_sw_t     plate_sw;
  tcc_sw_t     sw_seen;
  logic        acq_active;
  logic        conv_start;
  logic        shutdown;
  logic        touch_alert_n;
  logic [15:0] rv;
  logic [2:0]  chans[$];
  int          dly         = 3;
  int          n_errors    = 0;
  int          checks_done = 0;
  int          n_starts    = 0;
  int          cyc         = 0;
  int          acq_run     = 0;
  int          acq_len     = 0;
  int          t_last      = 0;
  int          t_gap       = 0;
  int          n           = 0;
  int          g1          = 0;

  always #4 ref_clk = ~ref_clk;

  tcc_conv_ctl #(
    .TMR_BASE_CYC    (50),
    .TMR_STEP_CYC    (5),
    .SETTLE_UNIT_CYC (4)
  ) uut (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata),
    .reg_rvalid    (reg_rvalid),
    .touch_sense   (touch_sense),
    .limit_hit     (limit_hit),
    .conv_done     (conv_done),
    .conv_data     (conv_data),
    .adc_chan      (adc_chan),
    .plate_sw      (plate_sw),
    .acq_active    (acq_active),
    .conv_start    (conv_start),
    .shutdown      (shutdown),
    .touch_alert_n (touch_alert_n)
  );

  tcc_adc_model adc (
    .ref_clk    (ref_clk),
    .conv_start (conv_start),
    .adc_chan   (adc_chan),
    .dly        (dly),
    .conv_done  (conv_done),
    .conv_data  (conv_data)
  );

  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // acquisition length, start stamps and timeout
  always @(negedge ref_clk) begin
    cyc++;
    if (acq_active === 1'b1) acq_run++;
    else if (acq_run > 0) begin
      acq_len = acq_run;
      acq_run = 0;
    end
    if (conv_start === 1'b1) begin
      n_starts++;
      chans.push_back(adc_chan);
      sw_seen = plate_sw;
      t_gap = cyc - t_last;
      t_last = cyc;
    end
    if (cyc == 80000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [15:0] e);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    repeat (4) if (reg_rvalid !== 1'b1) @(negedge ref_clk);
    rv = reg_rdata;
    `CHK(nm, e, rv)
  endtask

  task automatic waitn(input int k, input int lim);
    repeat (lim) if (n_starts < k) @(posedge ref_clk);
  endtask

  task automatic pause(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  function automatic tcc_sw_t exp_sw(input logic [2:0] c, input logic s);
    case (c)
      3'd7: return {4'b0011, s ? REF_SUPPLY : REF_Y};
      3'd6: return {4'b1100, s ? REF_SUPPLY : REF_X};
      3'd5, 3'd4: return s ? '0 : {4'b0110, REF_PRESS};
      default: return '0;
    endcase
  endfunction

  function automatic logic [7:0] slot(input logic [2:0] c);
    if (c >= 3'd4) return 8'h0f - {5'h00, c};
    return (c == 3'd1) ? 8'h0d : 8'h0c;
  endfunction

  initial begin
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd("cc_rst", `TCC_REG_CONV_CTL, `TCC_CC_RESET);
    rd("c2_rst", `TCC_REG_CTL2, `TCC_C2_RESET);
    rd("unmapped", 8'h30, 16'h0000);
    wr(`TCC_REG_RES_FIRST, 16'hffff);
    rd("res_ro", `TCC_REG_RES_FIRST, 16'h0000);
    `CHK("alert_idle", 1'b1, touch_alert_n)
    // every input code, both reference methods
    for (int s = 0; s < 2; s++) begin
      wr(`TCC_REG_CTL2, `TCC_C2_RESET | (16'(s) << 9));
      for (int c = 0; c < 8; c++) begin
        n = n_starts;
        wr(`TCC_REG_CONV_CTL, {1'b0, 3'(c), 2'b01, 2'(c), 8'h00});
        waitn(n + 1, 3000);
        pause(8);
        `CHK("starts", n + (c > 0), n_starts)
        rd("mode_clr", `TCC_REG_CONV_CTL,
           {1'b0, 3'(c), 2'b00, 2'(c), 8'h00});
        if (c > 0) begin
          `CHK("acq", `TCC_ACQ_BASE_CYC << (c % 4), acq_len)
          `CHK("chan", 3'(c), chans[$])
          `CHK("switch", exp_sw(3'(c), s[0]), sw_seen)
          rd("result", slot(3'(c)), {4'h0, 3'(c), 9'h0a5});
        end
      end
    end
    // slave sequence, slow converter, aux dropped
    wr(`TCC_REG_SEQ, 16'h00fe);
    wr(`TCC_REG_CTL2, `TCC_C2_RESET);
    dly = 20;
    chans.delete();
    n = n_starts;
    wr(`TCC_REG_CONV_CTL, 16'h0800);
    waitn(n + 6, 8000);
    pause(200);
    `CHK("seq_n", n + 6, n_starts)
    `CHK("seq", {3'd7, 3'd6, 3'd5, 3'd4, 3'd2, 3'd1},
         {chans[0], chans[1], chans[2], chans[3], chans[4], chans[5]})
    rd("seq_done", `TCC_REG_CONV_CTL, 16'h0000);
    rd("res_vbat", 8'h0c, {4'h0, 3'd2, 9'h0a5});
    rd("res_ypos", 8'h08, {4'h0, 3'd7, 9'h0a5});
    // repeat interval at two timer codes
    wr(`TCC_REG_SEQ, 16'h0002);
    dly = 3;
    for (int k = 1; k < 4; k += 2) begin
      wr(`TCC_REG_CONV_CTL, 16'h0000);
      n = n_starts;
      wr(`TCC_REG_CONV_CTL, 16'h0800 | 16'(k));
      waitn(n + 3, 2000);
      if (k == 1) g1 = t_gap;
    end
    `CHK("tmr_step", 10, t_gap - g1)
    `CHK("tmr_base", 1'b1, g1 >= 50)
    rd("mode_hold", `TCC_REG_CONV_CTL, 16'h0803);
    wr(`TCC_REG_CONV_CTL, 16'h0000);
    pause(20);
    n = n_starts;
    pause(400);
    `CHK("halt", n, n_starts)
    rd("res_kept", 8'h0d, {4'h0, 3'd1, 9'h0a5});
    // master: wait for touch, repeat while touched
    n = n_starts;
    wr(`TCC_REG_CONV_CTL, 16'h0c01);
    pause(400);
    `CHK("no_touch", n, n_starts)
    @(negedge ref_clk);
    touch_sense = 1'b1;
    waitn(n + 1, 300);
    `CHK("touch_go", n + 1, n_starts)
    `CHK("pen_down", 1'b0, touch_alert_n)
    waitn(n + 3, 1000);
    `CHK("held", n + 3, n_starts)
    @(negedge ref_clk);
    touch_sense = 1'b0;
    pause(400);
    n = n_starts;
    pause(800);
    `CHK("released", n, n_starts)
    @(negedge ref_clk);
    touch_sense = 1'b1;
    waitn(n + 1, 300);
    `CHK("retouch", n + 1, n_starts)
    // alert pin reports limits when pen alert is off
    wr(`TCC_REG_CONV_CTL, 16'h8000);
    @(negedge ref_clk);
    limit_hit = 1'b1;
    pause(3);
    `CHK("limit_on", 1'b0, touch_alert_n)
    @(negedge ref_clk);
    limit_hit = 1'b0;
    pause(3);
    `CHK("pen_off", 1'b1, touch_alert_n)
    // shutdown overrides a start
    @(negedge ref_clk);
    touch_sense = 1'b0;
    wr(`TCC_REG_CTL2, 16'h0040);
    pause(2);
    `CHK("shutdown", 1'b1, shutdown)
    n = n_starts;
    wr(`TCC_REG_CONV_CTL, 16'h0800);
    pause(400);
    `CHK("pwr_block", n, n_starts)
    summarize();
  end
endmodule // touch_adc_conversion_control_tb_top
